//--- bench/rsc_core_bench.sv
// self-checking bench for the serial rheostat command core
`timescale 1ns/1ps
module rsc_core_bench;
  // short store, still longer than one frame so a frame lands inside it
  localparam int unsigned PROG = 2000;
  logic clk, rst, sclk, din, sync_n, sdo_o, sdo_oe_n;
  logic [9:0] wiper_code;
  logic shutdown, calibration_disable, fuse_busy;
  wire logic sdo_line;
  int fails, total_checks, seed;
  logic [31:0] r;
  logic [9:0] w1, v;

  // pull-up wins whenever the core lets go of the line
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo_o;

  rsc_core #(.PROG_CYCLES(PROG)) DUT (
    .clk(clk),
    .rst(rst),
    .sclk(sclk),
    .din(din),
    .sync_n(sync_n),
    .sdo_o(sdo_o),
    .sdo_oe_n(sdo_oe_n),
    .wiper_code(wiper_code),
    .shutdown(shutdown),
    .calibration_disable(calibration_disable),
    .fuse_busy(fuse_busy)
  );

  rsc_spi_host partner (
    .sclk(sclk),
    .din(din),
    .sync_n(sync_n),
    .sdo_line(sdo_line)
  );

  // core clock, 4 ns
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic [31:0] word(input logic [3:0] c,
                                       input logic [9:0] d);
    return {18'h00000, c, d}; // command in bits 13..10
  endfunction

  // control readback: zeros above, then success, cal, write, program
  function automatic logic [9:0] exp_ctrl(input logic ok, input logic cal,
                                          input logic wr, input logic en);
    return {6'h00, ok, cal, wr, en};
  endfunction

  // one frame, then a gap long enough for decode and the next readback
  task automatic frm(input int n, input logic [31:0] w);
    @(negedge clk);
    partner.xfer(n, w, r);
    repeat (15) @(negedge clk);
  endtask

  // read command, then a no-op frame that carries the answer
  task automatic rd(input logic [31:0] w);
    frm(16, w);
    frm(16, 32'h00000000);
  endtask

  // bounded wait on the store flag; running out ends the run
  task automatic wait_busy(input logic lvl);
    int k;
    k = 0;
    while (fuse_busy !== lvl && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k == 3000) begin
      fails++;
      end_sim();
    end
  endtask

  initial begin
    seed = 32'h8B3B0F63;
    fails = 0;
    total_checks = 0;
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check(wiper_code, rsc_pkg::MIDSCALE);
    check(shutdown, 1'b0);
    check(calibration_disable, 1'b0);
    check(fuse_busy, 1'b0);
    frm(16, word(rsc_pkg::CMD_WR_WIPER, 10'h3FF));
    check(wiper_code, rsc_pkg::MIDSCALE);
    // store while program enable is still low must not start
    frm(16, word(rsc_pkg::CMD_STORE, 10'h000));
    check(fuse_busy, 1'b0);
    rd(word(rsc_pkg::CMD_RD_CTRL, 10'h000));
    check(r[9:0], exp_ctrl(1'b0, 1'b0, 1'b0, 1'b0));
    $display("test done: reset state and write guard");
    frm(16, word(rsc_pkg::CMD_WR_CTRL, 10'h003));
    frm(16, 32'h00000000);
    check(r[15:0], 16'h1C03);
    // random wiper codes written and read back
    for (int i = 0; i < 4; i++) begin
      v = 10'($random(seed));
      frm(16, word(rsc_pkg::CMD_WR_WIPER, v));
      check(wiper_code, v);
      rd(word(rsc_pkg::CMD_RD_WIPER, 10'h000));
      check(r[9:0], v);
    end
    frm(16, word(rsc_pkg::CMD_RESET, 10'h000));
    check(wiper_code, rsc_pkg::MIDSCALE);
    frm(15, word(rsc_pkg::CMD_WR_WIPER, 10'h123));
    check(wiper_code, rsc_pkg::MIDSCALE);
    $display("test done: wiper writes, reads and bad length");
    w1 = 10'($random(seed));
    frm(16, word(rsc_pkg::CMD_WR_WIPER, w1));
    frm(16, word(rsc_pkg::CMD_STORE, 10'h000));
    check(fuse_busy, 1'b1);
    frm(16, word(rsc_pkg::CMD_WR_WIPER, ~w1));
    wait_busy(1'b0);
    repeat (12) @(negedge clk);
    check(wiper_code, w1);
    rd(word(rsc_pkg::CMD_RD_LAST, 10'h000));
    check(r[5:0], 6'h01);
    rd(word(rsc_pkg::CMD_RD_CTRL, 10'h000));
    check(r[9:0], exp_ctrl(1'b1, 1'b0, 1'b1, 1'b1));
    rd(word(rsc_pkg::CMD_RD_FUSE, 10'h001));
    check(r[9:0], w1);
    rd(word(rsc_pkg::CMD_RD_FUSE, 10'h3C0));
    check(r[9:0], 10'h000);
    // one past the last location reads as zero, not as stale data
    rd(word(rsc_pkg::CMD_RD_FUSE, 10'h033));
    check(r[9:0], 10'h000);
    $display("test done: fuse store and readback");
    frm(16, word(rsc_pkg::CMD_WR_WIPER, 10'h0AA));
    frm(16, word(rsc_pkg::CMD_SHDN, 10'h001));
    check(shutdown, 1'b1);
    check(wiper_code, 10'h0AA);
    frm(16, word(rsc_pkg::CMD_WR_WIPER, 10'h3C3));
    check(wiper_code, 10'h3C3);
    frm(16, word(rsc_pkg::CMD_SHDN, 10'h000));
    check(shutdown, 1'b0);
    frm(16, word(rsc_pkg::CMD_SHDN, 10'h001));
    frm(16, word(rsc_pkg::CMD_RESET, 10'h000));
    check(shutdown, 1'b0);
    check(wiper_code, w1);
    $display("test done: shutdown and reload");
    frm(16, word(rsc_pkg::CMD_WR_CTRL, 10'h007));
    check(calibration_disable, 1'b1);
    // two parts chained: the far word passes through during bits 15..0
    frm(32, {16'h1234, 16'h06F0});
    check(r[31:16], 16'h1C07);
    check(r[15:0], 16'h1234);
    check(wiper_code, 10'h2F0);
    frm(16, {16'h0000, rsc_pkg::HIZ_WORD});
    frm(16, 32'h00000000);
    check(r[15:0], rsc_pkg::HIZ_WORD);
    frm(16, 32'h00000000);
    check(r[15:0], 16'hFFFF);
    // still floating during the frame that cancels the float
    frm(16, word(rsc_pkg::CMD_WR_WIPER, 10'h011));
    check(r[15:0], 16'hFFFF);
    check(wiper_code, 10'h011);
    frm(16, 32'h00000000);
    check(r[15:0], 16'h0411);
    $display("test done: chain and released output");
    end_sim();
  end
endmodule // rsc_core_bench

//--- bench/rsc_spi_host.sv
// serial controller model that drives the link of the command core
`timescale 1ns/1ps
module rsc_spi_host (
  output logic sclk,
  output logic din,
  output logic sync_n,
  input wire logic sdo_line
);
  localparam int HALF = 80; // 160 ns period, slow for pull-up edges

  // link idles with the strobe high and the clock stopped low
  initial begin
    sclk = 1'b0;
    din = 1'b0;
    sync_n = 1'b1;
  end

  // n bits msb first; reply bit taken just before each falling edge
  task automatic xfer(input int n, input logic [31:0] w,
                      output logic [31:0] r);
    r = '0;
    sync_n = 1'b0; // strobe held low across every bit
    #(HALF + 1.3); // keeps link edges off the core clock's edges
    for (int i = n - 1; i >= 0; i--) begin
      din = w[i];
      sclk = 1'b1;
      #(HALF);
      r = {r[30:0], sdo_line}; // reply settled after rising edge
      sclk = 1'b0;
      #(HALF);
    end
    din = ~din; // released data must not look like the last bit
    sync_n = 1'b1; // frame closed, length is the caller's
    #(HALF);
  endtask
endmodule // rsc_spi_host

//--- core/rsc_core.sv
// serial command core: link shifter, command decode, fuse store, readback
`timescale 1ns/1ps
module rsc_core #(
  parameter int unsigned PROG_CYCLES = rsc_pkg::PROG_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic din,
  input wire logic sync_n,
  output logic sdo_o,
  output logic sdo_oe_n,
  output logic [9:0] wiper_code,
  output logic shutdown,
  output logic calibration_disable,
  output logic fuse_busy
);
  localparam int TW = $clog2(PROG_CYCLES + 1);

  // ---------------- link side (serial clock) ----------------
  logic link_rst_r;
  logic [15:0] rx_sr;
  logic [3:0] cnt_l;
  logic tog_l;
  logic fresh_l;
  logic [3:0] idx_l;
  logic past_l;
  logic hiz_r;
  logic resp_sel_r;
  logic [15:0] resp_r;

  // first-edge marker, armed by strobe or link reset since sclk may stop
  always_ff @(negedge sclk or posedge sync_n or posedge link_rst_r) begin
    if (sync_n || link_rst_r) begin
      fresh_l <= 1'b1;
    end else begin
      fresh_l <= 1'b0;
    end
  end

  // din sampled on falling edge; count kept after frame for the decoder
  always_ff @(negedge sclk or posedge link_rst_r) begin
    if (link_rst_r) begin
      rx_sr <= 16'h0000;
      cnt_l <= 4'h0;
      tog_l <= 1'b0;
    end else if (!sync_n) begin
      rx_sr <= {rx_sr[14:0], din};
      if (fresh_l) begin
        cnt_l <= 4'h1;
        tog_l <= ~tog_l;
      end else begin
        cnt_l <= cnt_l + 4'h1;
      end
    end
  end

  // open-drain output, updated on rising edge; released between frames
  always_ff @(posedge sclk or posedge sync_n or posedge link_rst_r) begin
    if (sync_n || link_rst_r) begin
      idx_l <= 4'h0;
      past_l <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else begin
      idx_l <= idx_l + 4'h1;
      if (idx_l == 4'hF) begin
        past_l <= 1'b1;
      end
      if (hiz_r) begin
        sdo_oe_n <= 1'b1;
      end else if (resp_sel_r && !past_l) begin
        sdo_oe_n <= resp_r[4'hF - idx_l];
      end else begin
        sdo_oe_n <= rx_sr[15];
      end
    end
  end

  // ---------------- core side (clk) ----------------
  logic sy1_r, sy2_r, sy3_r;
  logic t1_r, t2_r, seen_r;
  logic pend_r, ok_r;
  rsc_pkg::rsc_frame_s word_r;
  rsc_pkg::rsc_ctrl_s ctrl_r;
  rsc_pkg::rsc_prog_e state_r;
  logic [9:0] wiper_r;
  logic [9:0] burn_val_r;
  logic [5:0] last_r;
  logic [TW-1:0] timer_r;
  logic shdn_r;
  logic arm_r;
  logic [9:0] fuse_mem [1:rsc_pkg::FUSE_LOCS];
  logic frame_end, go, burn_done;
  logic [3:0] cmd;
  logic [9:0] data;
  logic [9:0] fuse_rd;
  logic [9:0] fuse_last;

  function automatic logic is_read(input logic [3:0] c);
    is_read = (c == rsc_pkg::CMD_RD_WIPER) || (c == rsc_pkg::CMD_RD_FUSE) ||
      (c == rsc_pkg::CMD_RD_LAST) || (c == rsc_pkg::CMD_RD_CTRL);
  endfunction

  // reset for the link flops, taken from a core flop, not the raw port
  always_ff @(posedge clk) begin
    link_rst_r <= rst;
  end

  // strobe and bit toggle pass two flops; first stages feed nothing else
  always_ff @(posedge clk) begin
    if (rst) begin
      sy1_r <= 1'b1;
      sy2_r <= 1'b1;
      sy3_r <= 1'b1;
      t1_r <= 1'b0;
      t2_r <= 1'b0;
    end else begin
      sy1_r <= sync_n;
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      t1_r <= tog_l;
      t2_r <= t1_r;
    end
  end

  assign frame_end = sy2_r && !sy3_r;
  assign cmd = word_r.cmd;
  assign data = word_r.data;
  assign go = pend_r && ok_r && (state_r == rsc_pkg::PROG_IDLE);
  assign burn_done = (state_r == rsc_pkg::PROG_BURN) &&
    (timer_r == TW'(PROG_CYCLES - 1));
  // reserved location zero and codes past 50 read as zero
  assign fuse_rd = (data[5:0] != rsc_pkg::FUSE_NONE &&
    data[5:0] <= 6'(rsc_pkg::FUSE_LOCS)) ? fuse_mem[data[5:0]] : 10'h000;
  assign fuse_last = (last_r == rsc_pkg::FUSE_NONE) ? rsc_pkg::MIDSCALE :
    fuse_mem[last_r];

  // word captured after the strobe rose; shift register is quiet by then
  always_ff @(posedge clk) begin
    if (rst) begin
      word_r <= '0;
      ok_r <= 1'b0;
      pend_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      pend_r <= frame_end;
      if (frame_end) begin
        word_r <= rx_sr;
        ok_r <= (t2_r != seen_r) && (cnt_l == 4'h0);
        seen_r <= t2_r;
      end
    end
  end

  // fuse store sequencer; all frames dropped while burning
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= rsc_pkg::PROG_IDLE;
      timer_r <= '0;
      last_r <= rsc_pkg::FUSE_NONE;
      burn_val_r <= 10'h000;
    end else begin
      case (state_r)
        rsc_pkg::PROG_IDLE: begin
          timer_r <= '0;
          if (go && cmd == rsc_pkg::CMD_STORE &&
              ctrl_r.fuse_program_enable &&
              last_r < 6'(rsc_pkg::FUSE_LOCS)) begin
            state_r <= rsc_pkg::PROG_BURN;
            burn_val_r <= wiper_r;
          end
        end
        rsc_pkg::PROG_BURN: begin
          timer_r <= timer_r + TW'(1);
          if (burn_done) begin
            state_r <= rsc_pkg::PROG_IDLE;
            last_r <= last_r + 6'h01;
          end
        end
        default: state_r <= rsc_pkg::PROG_IDLE;
      endcase
    end
  end

  // fuse array has no reset: it models nonvolatile cells
  always_ff @(posedge clk) begin
    if (burn_done) begin
      fuse_mem[last_r + 6'h01] <= burn_val_r;
    end
  end

  // control flags; success cleared when a store starts, set when it ends
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= rsc_pkg::CTRL_RST;
    end else begin
      if (go && cmd == rsc_pkg::CMD_WR_CTRL) begin
        ctrl_r.calibration_disable <= data[2];
        ctrl_r.wiper_write_allow <= data[1];
        ctrl_r.fuse_program_enable <= data[0];
      end
      if (go && cmd == rsc_pkg::CMD_STORE && ctrl_r.fuse_program_enable) begin
        ctrl_r.fuse_program_ok <= 1'b0;
      end
      if (burn_done) begin
        ctrl_r.fuse_program_ok <= 1'b1;
      end
    end
  end

  // wiper register; writes blocked unless allowed, rst loads midscale, reset command reloads fuse
  always_ff @(posedge clk) begin
    if (rst) begin
      wiper_r <= rsc_pkg::MIDSCALE;
    end else if (go && cmd == rsc_pkg::CMD_WR_WIPER &&
                 ctrl_r.wiper_write_allow) begin
      wiper_r <= data;
    end else if (go && cmd == rsc_pkg::CMD_RESET) begin
      wiper_r <= fuse_last;
    end
  end

  // shutdown flag
  always_ff @(posedge clk) begin
    if (rst) begin
      shdn_r <= 1'b0;
    end else if (go && cmd == rsc_pkg::CMD_SHDN) begin
      shdn_r <= data[0];
    end else if (go && cmd == rsc_pkg::CMD_RESET) begin
      shdn_r <= 1'b0;
    end
  end

  // readback word for the next frame; held until the next accepted frame
  always_ff @(posedge clk) begin
    if (rst) begin
      resp_sel_r <= 1'b0;
      resp_r <= 16'h0000;
    end else if (go) begin
      resp_sel_r <= is_read(cmd);
      case (cmd)
        rsc_pkg::CMD_RD_WIPER: resp_r <= {6'h00, wiper_r};
        rsc_pkg::CMD_RD_FUSE: resp_r <= {6'h00, fuse_rd};
        rsc_pkg::CMD_RD_LAST: resp_r <= {10'h000, last_r};
        rsc_pkg::CMD_RD_CTRL: resp_r <= {12'h000, ctrl_r};
        default: resp_r <= 16'h0000;
      endcase
    end
  end

  // float request: arming word, then a no-op; any other command undoes it
  always_ff @(posedge clk) begin
    if (rst) begin
      arm_r <= 1'b0;
      hiz_r <= 1'b0;
    end else if (go) begin
      arm_r <= (word_r == rsc_pkg::HIZ_WORD);
      if (cmd != rsc_pkg::CMD_NOP) begin
        hiz_r <= 1'b0;
      end else if (arm_r) begin
        hiz_r <= 1'b1;
      end
    end
  end

  // registered outputs; pin only ever pulls low
  always_ff @(posedge clk) begin
    if (rst) begin
      sdo_o <= 1'b0;
      wiper_code <= rsc_pkg::MIDSCALE;
      shutdown <= 1'b0;
      calibration_disable <= 1'b0;
      fuse_busy <= 1'b0;
    end else begin
      sdo_o <= 1'b0;
      wiper_code <= wiper_r;
      shutdown <= shdn_r;
      calibration_disable <= ctrl_r.calibration_disable;
      fuse_busy <= (state_r == rsc_pkg::PROG_BURN);
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_shdn_enter;
    go && cmd == rsc_pkg::CMD_SHDN && data[0] |=> shdn_r ##1 shutdown;
  endproperty
  a_shdn_enter: assert property (p_shdn_enter)
    else $error("shutdown not entered");

  property p_shdn_leave;
    go && (cmd == rsc_pkg::CMD_RESET ||
      (cmd == rsc_pkg::CMD_SHDN && !data[0])) |=> !shdn_r;
  endproperty
  a_shdn_leave: assert property (p_shdn_leave)
    else $error("shutdown not left");

  property p_wr_blocked;
    go && cmd == rsc_pkg::CMD_WR_WIPER && !ctrl_r.wiper_write_allow
      |=> $stable(wiper_r);
  endproperty
  a_wr_blocked: assert property (p_wr_blocked)
    else $error("wiper changed while protected");

  property p_wr_ok;
    go && cmd == rsc_pkg::CMD_WR_WIPER && ctrl_r.wiper_write_allow
      |=> wiper_r == $past(data) ##1 wiper_code == $past(data, 2);
  endproperty
  a_wr_ok: assert property (p_wr_ok)
    else $error("wiper write lost");

  property p_reset_mid;
    go && cmd == rsc_pkg::CMD_RESET && last_r == rsc_pkg::FUSE_NONE
      |=> wiper_r == rsc_pkg::MIDSCALE;
  endproperty
  a_reset_mid: assert property (p_reset_mid)
    else $error("reset did not load midscale");

  property p_store_gated;
    go && cmd == rsc_pkg::CMD_STORE && !ctrl_r.fuse_program_enable
      |=> state_r == rsc_pkg::PROG_IDLE;
  endproperty
  a_store_gated: assert property (p_store_gated)
    else $error("store ran without enable");

  property p_burn_lock;
    pend_r && ok_r && state_r == rsc_pkg::PROG_BURN && !burn_done
      |=> $stable(wiper_r) && $stable(ctrl_r) && $stable(shdn_r);
  endproperty
  a_burn_lock: assert property (p_burn_lock)
    else $error("frame acted on during store");

  property p_burn_ok;
    burn_done |=> ctrl_r.fuse_program_ok && last_r == $past(last_r) + 6'h01;
  endproperty
  a_burn_ok: assert property (p_burn_ok)
    else $error("store completion not flagged");

  property p_rd_wiper;
    go && cmd == rsc_pkg::CMD_RD_WIPER
      |=> resp_sel_r && resp_r[9:0] == $past(wiper_r);
  endproperty
  a_rd_wiper: assert property (p_rd_wiper)
    else $error("wiper readback wrong");

  property p_rd_ctrl;
    go && cmd == rsc_pkg::CMD_RD_CTRL
      |=> resp_sel_r && resp_r == {12'h000, $past(ctrl_r)};
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl)
    else $error("control readback wrong");

  property p_echo;
    go && !is_read(cmd) |=> !resp_sel_r;
  endproperty
  a_echo: assert property (p_echo)
    else $error("stale readback selected");

  property p_cov_store;
    state_r == rsc_pkg::PROG_IDLE ##1 state_r == rsc_pkg::PROG_BURN;
  endproperty
  c_store: cover property (p_cov_store);
  c_shdn: cover property (go && cmd == rsc_pkg::CMD_SHDN && data[0]);
  c_hiz: cover property ($rose(hiz_r));
  c_rd_fuse: cover property (go && cmd == rsc_pkg::CMD_RD_FUSE);
endmodule // rsc_core

//--- core/rsc_pkg.sv
// constants, types and command codes of the serial rheostat command core
// Notes on behaviour
// - frame holds four-bit command in bits 13..10, ten data bits; decoded at strobe rise
// - bits are counted per frame; only multiples of 16 are accepted
// - fuse store takes 350 ms; incoming frames are locked out meanwhile
// - command 9 with data bit 0 set enters shutdown, A open, wiper kept
// - every command still runs while in shutdown
// - command 9 with bit 0 clear, or command 4, leaves shutdown
// - command 4 loads wiper from most recently programmed fuse location
// - command 4 with no fuse location programmed loads midscale
// - control word: bits 9..4 read zero, bits 3..0 are the four flags
// - program enable resets low; set it to allow fuse stores
// - write allow resets low; set it to let wiper writes land
// - without write allow the wiper stays at fuse value or midscale
// - calibration disable resets low and is exported to the resistor array
// - program success resets low, set when a fuse store completes
// - fuse read selects location by data bits 5..0, 1 to 50; zero reserved
// - after wiper read, next frame returns wiper in its last ten bits
// - after fuse read, next frame returns the location value in last ten bits
// - after last-address read, next frame returns that address in six lsbs
// - after control read, next frame returns control flags in last four bits
// - with no read pending, the previous frame word is shifted out again
// - serial output changes on the rising serial clock edge
// - serial output is open drain: pull low or release only
// - word 0x8001 followed by a no-op frame floats the serial output
package rsc_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 4;
  localparam int DATA_W = 10;
  localparam int FUSE_LOCS = 50;
  localparam int FUSE_AW = 6;
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_WR_WIPER = 4'h1;
  localparam logic [3:0] CMD_RD_WIPER = 4'h2;
  localparam logic [3:0] CMD_STORE = 4'h3;
  localparam logic [3:0] CMD_RESET = 4'h4;
  localparam logic [3:0] CMD_RD_FUSE = 4'h5;
  localparam logic [3:0] CMD_RD_LAST = 4'h6;
  localparam logic [3:0] CMD_WR_CTRL = 4'h7;
  localparam logic [3:0] CMD_RD_CTRL = 4'h8;
  localparam logic [3:0] CMD_SHDN = 4'h9;
  localparam logic [9:0] MIDSCALE = 10'h200;
  localparam logic [15:0] HIZ_WORD = 16'h8001;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam logic [5:0] FUSE_NONE = 6'h00;
  localparam int PROG_MS = 350;
  localparam int CLK_MHZ = 250;
  localparam int PROG_CYC = PROG_MS * CLK_MHZ * 1000;

  // control flags, msb first as they sit in the data field
  typedef struct packed {
    logic fuse_program_ok;
    logic calibration_disable;
    logic wiper_write_allow;
    logic fuse_program_enable;
  } rsc_ctrl_s;

  // one received 16-bit frame
  typedef struct packed {
    logic [1:0] spare;
    logic [3:0] cmd;
    logic [9:0] data;
  } rsc_frame_s;

  typedef enum logic {PROG_IDLE, PROG_BURN} rsc_prog_e;
endpackage
